// ### core/ufc_regs.sv
// Contract
// [RL1] Four resume/pause character registers, reset zero.
// [RL2] Status bit0 shows remote pause hold-off.
// [RL3] Status bit1 shows we stopped the remote.
// [RL4] Status bit2 sets on resume/pause receipt.
// [RL5] Status bit3 sets on special character match.
// [RL6] Detect flags raise level-six interrupt when enabled.
// [RL7] Status bits 7:4 read zero.
// [RL8] Transmit interrupt trigger level register.
// [RL9] Receive interrupt trigger level register.
// [RL10] Low flow threshold releases halted remote.
// [RL11] High flow threshold halts remote sender.
// [RL12] Prescale bits 3:0 hold N term.
// [RL13] Software keeps M term at 0..2.
// [RL14] Count register selected by special-function bit.
// [RL15] Receive mode returns receive FIFO fill.
// [RL16] Other mode returns line status fill.
// [RL17] Insert pause/resume characters at thresholds.
// [RL18] Auto request-to-send follows thresholds.
// [RL19] Auto clear-to-send blocks new transmissions.
// [RL20] Compare received characters against pause characters.
// [RL21] Detect event beats simultaneous read clear.
// [RL22] Writes to read-only registers are ignored.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps

module ufc_regs
	import ufc_pkg::*;
(
	// Clock and reset.
	input  wire logic                 core_clk_i,
	input  wire logic                 rstn_i,
	// Register port.
	input  wire ufc_pkg::ufc_req_t    req_i,
	output logic [9:0]                rdata_o,
	// Special-function select bit from the main register set.
	input  wire logic                 special_function_select_i,
	// Receive and line status levels.
	input  wire ufc_pkg::ufc_level_t  level_i,
	// Received character stream.
	input  wire logic                 rx_valid_i,
	input  wire logic [7:0]           rx_char_i,
	// Clear-to-send pin, active low.
	input  wire logic                 cts_n_i,
	// Flow outputs toward the transmitter.
	output logic                      rts_n_o,
	output logic                      tx_allow_o,
	output logic                      ins_req_o,
	output logic [7:0]                ins_char_o,
	input  wire logic                 ins_ack_i,
	// Level-six interrupt request and trigger levels.
	output logic                      irq6_o,
	output logic [7:0]                tx_irq_level_o,
	output logic [7:0]                rx_irq_level_o,
	output logic [7:0]                prescale_n_term_o,
	output logic [3:0]                prescale_m_term_o
);
	import ufc_pkg::*;

	// Software-written registers.
	logic [7:0] resume_char_one_r, resume_char_two_r;
	logic [7:0] pause_char_one_r, pause_char_two_r;
	logic [7:0] tx_irq_threshold_r, rx_irq_threshold_r;
	logic [7:0] flow_low_threshold_r, flow_high_threshold_r;
	logic [7:0] baud_prescale_r;
	logic [9:0] control_r;
	// Flow state and sticky flags.
	logic       held_off_r, remote_stopped_r;
	logic       flow_det_r, spec_det_r;
	logic       pause_sent_r;
	logic       ins_req_r;
	logic [7:0] ins_char_r;
	logic [9:0] rdata_r;

	// Write decode as named wires.
	wire wr_resume1 = req_i.wr && (req_i.addr == UFC_OFS_RESUME1);
	wire wr_resume2 = req_i.wr && (req_i.addr == UFC_OFS_RESUME2);
	wire wr_pause1  = req_i.wr && (req_i.addr == UFC_OFS_PAUSE1);
	wire wr_pause2  = req_i.wr && (req_i.addr == UFC_OFS_PAUSE2);
	wire wr_txlvl   = req_i.wr && (req_i.addr == UFC_OFS_TX_IRQ_LVL);
	wire wr_rxlvl   = req_i.wr && (req_i.addr == UFC_OFS_RX_IRQ_LVL);
	wire wr_low     = req_i.wr && (req_i.addr == UFC_OFS_FLOW_LOW);
	wire wr_high    = req_i.wr && (req_i.addr == UFC_OFS_FLOW_HIGH);
	wire wr_pre     = req_i.wr && (req_i.addr == UFC_OFS_PRESCALE);
	wire wr_ctrl    = req_i.wr && (req_i.addr == UFC_OFS_CONTROL);
	// A status read clears the detect flags.
	wire rd_status  = req_i.rd && (req_i.addr == UFC_OFS_STATUS);

	// Control fields.
	wire       enhanced   = control_r[UFC_CT_ENHANCED];
	ufc_txfc_t tx_mode;
	assign tx_mode = ufc_txfc_t'(control_r[UFC_CT_TX_MODE_LO +: 2]);
	wire       spec_en    = control_r[UFC_CT_SPECIAL] && enhanced;
	wire       auto_rts   = control_r[UFC_CT_AUTO_RTS] && enhanced;
	wire       auto_cts   = control_r[UFC_CT_AUTO_CTS] && enhanced;
	wire       inband_on  = enhanced && (tx_mode == UFC_TXFC_SET1 ||
		tx_mode == UFC_TXFC_SET2);

	// Threshold comparisons against the receive level.
	wire at_high  = level_i.rx_level >= flow_high_threshold_r;   // [RL11]
	wire below_lo = level_i.rx_level <  flow_low_threshold_r;    // [RL10]

	// Character set chosen by the in-band mode.
	wire [7:0] sel_pause  = (tx_mode == UFC_TXFC_SET2) ? pause_char_two_r : pause_char_one_r;
	wire [7:0] sel_resume = (tx_mode == UFC_TXFC_SET2) ? resume_char_two_r : resume_char_one_r;

	// Received character matching.
	wire hit_pause  = rx_valid_i && (rx_char_i == pause_char_one_r ||
		rx_char_i == pause_char_two_r);                           // [RL20]
	wire hit_resume = rx_valid_i && (rx_char_i == resume_char_one_r ||
		rx_char_i == resume_char_two_r);
	wire flow_event = enhanced && (hit_pause || hit_resume);
	wire spec_event = spec_en && hit_pause;                      // [RL20]

	// In-band insertion decisions; a new request waits for the last.
	wire want_pause  = inband_on && at_high && !pause_sent_r && !ins_req_r;    // [RL17]
	wire want_resume = inband_on && below_lo && pause_sent_r && !ins_req_r;   // [RL17]

	// Count register source, chosen by the special-function bit.
	wire [7:0] count_val = special_function_select_i ? level_i.rx_level   // [RL14] [RL15]
		: level_i.line_status_level;                                 // [RL16]

	// Status byte; upper nibble always zero.
	wire [7:0] status_val = {4'h0, spec_det_r, flow_det_r,                // [RL7]
		remote_stopped_r, held_off_r};

	// Read multiplexer; unmapped addresses read zero.
	logic [9:0] rd_mux;
	always_comb begin
		// Default covers unmapped offsets.
		rd_mux = 10'h000;
		unique case (req_i.addr)
			UFC_OFS_RESUME1:    rd_mux = {2'h0, resume_char_one_r};
			UFC_OFS_RESUME2:    rd_mux = {2'h0, resume_char_two_r};
			UFC_OFS_PAUSE1:     rd_mux = {2'h0, pause_char_one_r};
			UFC_OFS_PAUSE2:     rd_mux = {2'h0, pause_char_two_r};
			UFC_OFS_STATUS:     rd_mux = {2'h0, status_val};
			UFC_OFS_TX_IRQ_LVL: rd_mux = {2'h0, tx_irq_threshold_r};
			UFC_OFS_RX_IRQ_LVL: rd_mux = {2'h0, rx_irq_threshold_r};
			UFC_OFS_FLOW_LOW:   rd_mux = {2'h0, flow_low_threshold_r};
			UFC_OFS_FLOW_HIGH:  rd_mux = {2'h0, flow_high_threshold_r};
			UFC_OFS_PRESCALE:   rd_mux = {2'h0, baud_prescale_r};
			UFC_OFS_COUNT:      rd_mux = {2'h0, count_val};
			UFC_OFS_CONTROL:    rd_mux = control_r;
			default:            rd_mux = 10'h000;
		endcase
	end

	// Character registers; no write path exists for status or count.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			resume_char_one_r <= UFC_RST_BYTE;                        // [RL1]
			resume_char_two_r <= UFC_RST_BYTE;
			pause_char_one_r  <= UFC_RST_BYTE;
			pause_char_two_r  <= UFC_RST_BYTE;
		end else begin
			if (wr_resume1) resume_char_one_r <= req_i.wdata[7:0];    // [RL1]
			if (wr_resume2) resume_char_two_r <= req_i.wdata[7:0];
			if (wr_pause1)  pause_char_one_r  <= req_i.wdata[7:0];
			if (wr_pause2)  pause_char_two_r  <= req_i.wdata[7:0];
		end
	end

	// Level and prescale registers. The M term is stored as written;
	// values above two are the software's concern.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			tx_irq_threshold_r    <= UFC_RST_BYTE;                    // [RL8]
			rx_irq_threshold_r    <= UFC_RST_BYTE;                    // [RL9]
			flow_low_threshold_r  <= UFC_RST_BYTE;                    // [RL10]
			flow_high_threshold_r <= UFC_RST_BYTE;                    // [RL11]
			baud_prescale_r       <= UFC_RST_BYTE;                    // [RL12]
			control_r             <= UFC_RST_CTRL;
		end else begin
			if (wr_txlvl) tx_irq_threshold_r    <= req_i.wdata[7:0];  // [RL8]
			if (wr_rxlvl) rx_irq_threshold_r    <= req_i.wdata[7:0];  // [RL9]
			if (wr_low)   flow_low_threshold_r  <= req_i.wdata[7:0];
			if (wr_high)  flow_high_threshold_r <= req_i.wdata[7:0];
			if (wr_pre)   baud_prescale_r       <= req_i.wdata[7:0];  // [RL12] [RL13]
			if (wr_ctrl)  control_r             <= req_i.wdata;
		end
	end

	// Sticky detect flags: a new event wins over the read clear.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			flow_det_r <= 1'b0;
			spec_det_r <= 1'b0;
		end else begin
			flow_det_r <= flow_event | (flow_det_r & ~rd_status);      // [RL4] [RL21]
			spec_det_r <= spec_event | (spec_det_r & ~rd_status);      // [RL5] [RL21]
		end
	end

	// Hold-off from the remote: pause sets, resume clears. A pause and
	// resume in one character cannot both hit unless they are equal;
	// then pause wins, which is the safe side.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			held_off_r <= 1'b0;
		end else if (!enhanced) begin
			held_off_r <= 1'b0;
		end else if (hit_pause) begin
			held_off_r <= 1'b1;                                       // [RL2]
		end else if (hit_resume) begin
			held_off_r <= 1'b0;                                       // [RL2]
		end
	end

	// Our own stop signalling toward the remote end.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			pause_sent_r     <= 1'b0;
			rts_n_o          <= 1'b0;
			remote_stopped_r <= 1'b0;
		end else begin
			if (want_pause)  pause_sent_r <= 1'b1;                    // [RL17]
			else if (want_resume || !inband_on) pause_sent_r <= 1'b0;
			if (!auto_rts)   rts_n_o <= 1'b0;
			else if (at_high)  rts_n_o <= 1'b1;                       // [RL18]
			else if (below_lo) rts_n_o <= 1'b0;                       // [RL18]
			remote_stopped_r <= (pause_sent_r | want_pause) |
				(auto_rts & (at_high | (rts_n_o & ~below_lo)));      // [RL3]
		end
	end

	// Insertion request holds until the transmitter acknowledges it.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ins_req_r  <= 1'b0;
			ins_char_r <= UFC_RST_BYTE;
		end else if (want_pause) begin
			ins_req_r  <= 1'b1;
			ins_char_r <= sel_pause;                                  // [RL17]
		end else if (want_resume) begin
			ins_req_r  <= 1'b1;
			ins_char_r <= sel_resume;                                 // [RL17]
		end else if (ins_ack_i) begin
			ins_req_r  <= 1'b0;
		end
	end

	// Transmit permission: blocked by remote pause or, with auto clear-to-send on, inactive clear-to-send.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			tx_allow_o <= 1'b0;
		end else begin
			tx_allow_o <= !(auto_cts && cts_n_i) && !held_off_r;       // [RL19]
		end
	end

	// Interrupt, read data and mirrored outputs, all registered.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			irq6_o            <= 1'b0;
			rdata_r           <= 10'h000;
			tx_irq_level_o    <= UFC_RST_BYTE;
			rx_irq_level_o    <= UFC_RST_BYTE;
			prescale_n_term_o <= UFC_RST_BYTE;
			prescale_m_term_o <= 4'h0;
		end else begin
			irq6_o            <= control_r[UFC_CT_IRQ_EN] &
				((flow_det_r & ~rd_status) | (spec_det_r & ~rd_status) |
				flow_event | spec_event);                          // [RL6]
			rdata_r           <= req_i.rd ? rd_mux : 10'h000;         // [RL22]
			tx_irq_level_o    <= tx_irq_threshold_r;
			rx_irq_level_o    <= rx_irq_threshold_r;
			prescale_n_term_o <= {4'h0, baud_prescale_r[3:0]};       // [RL12]
			prescale_m_term_o <= baud_prescale_r[7:4];
		end
	end

	assign rdata_o    = rdata_r;
	assign ins_req_o  = ins_req_r;
	assign ins_char_o = ins_char_r;

	// Assertions.
	property p_det_keep;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rd_status && flow_event) |=> flow_det_r;
	endproperty
	a_det_keep: assert property (p_det_keep) else $error("detect lost on read"); // [RL21]

	property p_det_clear;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(rd_status && !flow_event && !spec_event) |=> (!flow_det_r && !spec_det_r);
	endproperty
	a_det_clear: assert property (p_det_clear) else $error("read did not clear"); // [RL4]

	property p_spec_set;
		@(posedge core_clk_i) disable iff (!rstn_i)
		spec_event |=> spec_det_r;
	endproperty
	a_spec_set: assert property (p_spec_set) else $error("special flag not set"); // [RL5]

	property p_rsvd_zero;
		@(posedge core_clk_i) disable iff (!rstn_i)
		$past(rd_status) |-> (rdata_o[7:4] == 4'h0);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // [RL7]

	property p_rts_high;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(auto_rts && at_high) |=> rts_n_o;
	endproperty
	a_rts_high: assert property (p_rts_high) else $error("rts not deasserted"); // [RL18]

	property p_cts_block;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(auto_cts && cts_n_i) |=> !tx_allow_o;
	endproperty
	a_cts_block: assert property (p_cts_block) else $error("tx allowed under cts"); // [RL19]

	property p_held;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(enhanced && hit_pause) |=> held_off_r ##1 !tx_allow_o;
	endproperty
	a_held: assert property (p_held) else $error("pause did not hold off"); // [RL2]

	property p_pause_ins;
		@(posedge core_clk_i) disable iff (!rstn_i)
		want_pause |=> (ins_req_o && ins_char_o == $past(sel_pause));
	endproperty
	a_pause_ins: assert property (p_pause_ins) else $error("pause not inserted"); // [RL17]

	property p_count;
		@(posedge core_clk_i) disable iff (!rstn_i)
		(req_i.rd && req_i.addr == UFC_OFS_COUNT && special_function_select_i)
		|=> (rdata_o[7:0] == $past(level_i.rx_level));
	endproperty
	a_count: assert property (p_count) else $error("count source wrong"); // [RL14]

endmodule : ufc_regs

// ### core/ufc_pkg.sv
package ufc_pkg;

	// Register offsets on the plain register port.
	localparam logic [7:0] UFC_OFS_RESUME1    = 8'h0B;
	localparam logic [7:0] UFC_OFS_RESUME2    = 8'h0C;
	localparam logic [7:0] UFC_OFS_PAUSE1     = 8'h0D;
	localparam logic [7:0] UFC_OFS_PAUSE2     = 8'h0E;
	localparam logic [7:0] UFC_OFS_STATUS     = 8'h0F;
	localparam logic [7:0] UFC_OFS_TX_IRQ_LVL = 8'h10;
	localparam logic [7:0] UFC_OFS_RX_IRQ_LVL = 8'h11;
	localparam logic [7:0] UFC_OFS_FLOW_LOW   = 8'h12;
	localparam logic [7:0] UFC_OFS_FLOW_HIGH  = 8'h13;
	localparam logic [7:0] UFC_OFS_PRESCALE   = 8'h14;
	localparam logic [7:0] UFC_OFS_COUNT      = 8'h15;
	localparam logic [7:0] UFC_OFS_CONTROL    = 8'h18;

	// Status register bit positions.
	localparam int UFC_ST_HELD_OFF  = 0;
	localparam int UFC_ST_REMOTE_TX = 1;
	localparam int UFC_ST_FLOW_DET  = 2;
	localparam int UFC_ST_SPEC_DET  = 3;

	// Control register bit positions.
	localparam int UFC_CT_TX_MODE_LO = 0;
	localparam int UFC_CT_ENHANCED   = 4;
	localparam int UFC_CT_SPECIAL    = 5;
	localparam int UFC_CT_AUTO_RTS   = 6;
	localparam int UFC_CT_AUTO_CTS   = 7;
	localparam int UFC_CT_COUNT_SEL  = 8;
	localparam int UFC_CT_IRQ_EN     = 9;

	// Reset values.
	localparam logic [7:0] UFC_RST_BYTE = 8'h00;
	localparam logic [9:0] UFC_RST_CTRL = 10'h000;

	// In-band transmit flow control modes.
	typedef enum logic [1:0] {
		UFC_TXFC_OFF  = 2'b00,
		UFC_TXFC_SET2 = 2'b01,
		UFC_TXFC_SET1 = 2'b10,
		UFC_TXFC_RSVD = 2'b11
	} ufc_txfc_t;

	// Register access request from software.
	typedef struct packed {
		logic [7:0] addr;
		logic [9:0] wdata;
		logic       wr;
		logic       rd;
	} ufc_req_t;

	// Live levels reported by the surrounding UART.
	typedef struct packed {
		logic [7:0] rx_level;
		logic [7:0] line_status_level;
	} ufc_level_t;

endpackage : ufc_pkg

// ### test/ufc_remote_model.sv
`timescale 1ns/10ps

// Far-side station: sends characters to us and takes the ones we insert.
module ufc_remote_model #(
	parameter int ACK_DLY = 3 // Cycles a slow remote line needs per insertion.
) (
	// Clock and reset.
	input  wire logic       core_clk_i,
	input  wire logic       rstn_i,
	// Commands from the bench.
	input  wire logic       send_i,
	input  wire logic [7:0] send_char_i,
	input  wire logic       stop_us_i,
	// Serial-side view of the block.
	output logic            rx_valid_o,
	output logic [7:0]      rx_char_o,
	output logic            cts_n_o,
	input  wire logic       ins_req_i,
	input  wire logic [7:0] ins_char_i,
	output logic            ins_ack_o,
	// Record of what was inserted.
	output logic [7:0]      last_ins_o,
	output logic [7:0]      n_ins_o
);
	logic [3:0] wait_r; // Cycles the pending insertion has waited.

	// A character is a one-cycle pulse; between pulses the data wobbles so that
	// a design sampling it outside the pulse does not see a steady value.
	always_ff @(posedge core_clk_i) begin
		rx_valid_o <= send_i && rstn_i;
		rx_char_o  <= !rstn_i ? 8'hA5 : (send_i ? send_char_i : ~rx_char_o);
		cts_n_o    <= stop_us_i;
	end

	// The acknowledge is a single pulse, so the held request is counted once.
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i || ins_ack_o) begin
			ins_ack_o <= 1'b0;
			wait_r    <= 4'h0;
		end else if (ins_req_i) begin
			wait_r <= wait_r + 4'h1;
			if (wait_r == 4'(ACK_DLY)) begin
				ins_ack_o  <= 1'b1;
				last_ins_o <= ins_char_i;
				n_ins_o    <= n_ins_o + 8'h01;
			end
		end
		if (!rstn_i) begin
			n_ins_o    <= 8'h00;
			last_ins_o <= 8'h00;
		end
	end
endmodule : ufc_remote_model

// ### test/testbench.sv
`timescale 1ns/10ps

module testbench;
	import ufc_pkg::*;
	logic       core_clk_i, rstn_i, sfs, rx_valid, cts_n, rts_n, tx_allow;
	logic       ins_req, ins_ack, irq6, send_i, stop_us;
	logic [7:0] rx_char, ins_char, txl, rxl, pn, send_char, last_ins, n_ins;
	logic [3:0] pm;
	logic [9:0] rdata, d;
	ufc_req_t   req;
	ufc_level_t level;
	int         mismatches = 0;
	int         n_tests    = 0;
	logic [7:0] rw_a [9] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14};

	ufc_regs u_ufc_regs (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata),
		.special_function_select_i(sfs), .level_i(level), .rx_valid_i(rx_valid),
		.rx_char_i(rx_char), .cts_n_i(cts_n), .rts_n_o(rts_n), .tx_allow_o(tx_allow),
		.ins_req_o(ins_req), .ins_char_o(ins_char), .ins_ack_i(ins_ack), .irq6_o(irq6),
		.tx_irq_level_o(txl), .rx_irq_level_o(rxl), .prescale_n_term_o(pn),
		.prescale_m_term_o(pm));

	ufc_remote_model u_ufc_remote_model (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.send_i(send_i), .send_char_i(send_char), .stop_us_i(stop_us), .rx_valid_o(rx_valid),
		.rx_char_o(rx_char), .cts_n_o(cts_n), .ins_req_i(ins_req), .ins_char_i(ins_char),
		.ins_ack_o(ins_ack), .last_ins_o(last_ins), .n_ins_o(n_ins));

	// Clock at 125 MHz.
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic close_out();
		if (mismatches == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One-cycle write; an idle cycle follows so no strobe is driven twice at one edge.
	task automatic wr(input logic [7:0] a, input logic [9:0] v);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_i);
		req <= '0;
		@(posedge core_clk_i);
	endtask : wr

	// Read data are valid only in the cycle after the strobe, so they are taken there.
	task automatic rchk(input string what, input logic [7:0] a, input logic [9:0] m,
		input logic [9:0] exp);
		req <= '{addr: a, wdata: 10'h000, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_i);
		req <= '0;
		#1 chk(what, rdata & m, exp);
		@(posedge core_clk_i);
	endtask : rchk

	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask : step

	// The character needs one edge in the model and one in the block.
	task automatic send(input logic [7:0] c);
		send_char <= c;
		send_i    <= 1'b1;
		@(posedge core_clk_i);
		send_i <= 1'b0;
		step(2);
	endtask : send

	// Bounded wait for the remote to take one more inserted character.
	task automatic wait_ins(input logic [7:0] c);
		logic [7:0] n0;
		int         k;
		n0 = n_ins;
		k  = 0;
		while (n_ins === n0 && k < 50) begin
			@(posedge core_clk_i);
			k++;
		end
		chk("insert count", 10'(n_ins), 10'(n0 + 8'h01));
		chk("insert char", 10'(last_ins), 10'(c));
	endtask : wait_ins

	// A hang counts as a failure.
	initial begin
		step(20000);
		mismatches++;
		close_out();
	end

	initial begin
		rstn_i    = 1'b0;
		req       = '0;
		sfs       = 1'b0;
		level     = '0;
		send_i    = 1'b0;
		send_char = 8'h00;
		stop_us   = 1'b0;
		step(2);
		rstn_i <= 1'b1;
		step(1);
		for (int a = 11; a <= 15; a++) begin
			rchk("reset", 8'(a), 10'h3FF, 10'h000);
		end
		for (int a = 16; a <= 21; a++) begin
			rchk("reset", 8'(a), 10'h3FF, 10'h000);
		end
		chk("allow", 10'(tx_allow), 10'h001);
		// Each writable byte keeps its own value; the M term stays in its safe range.
		// The inverted offset is built as a byte so no extension can reach bits 9:8.
		foreach (rw_a[i]) begin
			d = (rw_a[i] == 8'h14) ? 10'h02C : {2'b00, ~rw_a[i]};
			wr(rw_a[i], d);
		end
		foreach (rw_a[i]) begin
			d = (rw_a[i] == 8'h14) ? 10'h02C : {2'b00, ~rw_a[i]};
			rchk("rw", rw_a[i], 10'h0FF, d);
		end
		chk("txl", 10'(txl), 10'h0EF);
		chk("rxl", 10'(rxl), 10'h0EE);
		chk("n", 10'(pn), 10'h00C);
		chk("m", 10'(pm), 10'h002);
		// Read-only and unmapped places ignore writes.
		wr(8'h0F, 10'h3FF);
		wr(8'h15, 10'h3FF);
		wr(8'h20, 10'h3FF);
		rchk("ro status", 8'h0F, 10'h3FF, 10'h000);
		rchk("ro count", 8'h15, 10'h3FF, 10'h000);
		rchk("unmapped", 8'h20, 10'h3FF, 10'h000);
		// The select bit picks which level is read.
		level <= '{rx_level: 8'h21, line_status_level: 8'h05};
		sfs   <= 1'b1;
		rchk("rx count", 8'h15, 10'h3FF, 10'h021);
		sfs <= 1'b0;
		rchk("line count", 8'h15, 10'h3FF, 10'h005);
		level <= '0;
		wr(8'h0B, 10'h011);
		wr(8'h0C, 10'h091);
		wr(8'h0D, 10'h013);
		wr(8'h0E, 10'h093);
		wr(8'h18, 10'h230);
		send(8'h11);
		chk("irq", 10'(irq6), 10'h001);
		rchk("resume seen", 8'h0F, 10'h0FE, 10'h004);
		chk("irq clr", 10'(irq6), 10'h000);
		rchk("read clear", 8'h0F, 10'h00C, 10'h000);
		send(8'h93);
		rchk("pause seen", 8'h0F, 10'h00C, 10'h00C);
		send(8'h55);
		rchk("no match", 8'h0F, 10'h00C, 10'h000);
		// An event landing on the clearing read must survive it.
		send_char <= 8'h11;
		send_i    <= 1'b1;
		@(posedge core_clk_i);
		send_i <= 1'b0;
		rchk("race", 8'h0F, 10'h0FF, 10'h001);
		rchk("kept", 8'h0F, 10'h004, 10'h004);
		wr(8'h18, 10'h030);
		send(8'h13);
		chk("irq off", 10'(irq6), 10'h000);
		rchk("flag no irq", 8'h0F, 10'h00C, 10'h00C);
		chk("held", 10'(tx_allow), 10'h000);
		// Resume so that the pause above no longer holds the transmitter off.
		send(8'h11);
		// Request-to-send follows the thresholds with hysteresis.
		wr(8'h12, 10'h004);
		wr(8'h13, 10'h010);
		wr(8'h18, 10'h050);
		level <= '{rx_level: 8'h10, line_status_level: 8'h00};
		step(3);
		chk("rts high", 10'(rts_n), 10'h001);
		rchk("stopped", 8'h0F, 10'h002, 10'h002);
		level.rx_level <= 8'h04;
		step(3);
		chk("rts hold", 10'(rts_n), 10'h001);
		level.rx_level <= 8'h03;
		step(3);
		chk("rts low", 10'(rts_n), 10'h000);
		rchk("resumed", 8'h0F, 10'h002, 10'h000);
		// Clear-to-send only blocks once the auto mode is on.
		stop_us <= 1'b1;
		step(3);
		chk("cts off", 10'(tx_allow), 10'h001);
		wr(8'h18, 10'h090);
		step(2);
		chk("cts block", 10'(tx_allow), 10'h000);
		stop_us <= 1'b0;
		step(3);
		chk("cts go", 10'(tx_allow), 10'h001);
		// Both in-band character sets, pause then resume.
		for (int m = 0; m < 2; m++) begin
			wr(8'h18, m ? 10'h031 : 10'h032);
			level.rx_level <= 8'h11;
			wait_ins(m ? 8'h93 : 8'h13);
			level.rx_level <= 8'h03;
			wait_ins(m ? 8'h91 : 8'h11);
		end
		close_out();
	end
endmodule : testbench
